// >>> logic/spim_fifo.sv
`timescale 1ns/10ps
module spim_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic  clk,
    input wire logic  rst_n,
    // Buffer ports
    spim_fifo_if.store f
);
    localparam int AWF = $clog2(DEPTH);

    logic [W-1:0] mem_reg [DEPTH];
    logic [AWF-1:0] wr_reg;
    logic [AWF-1:0] rd_reg;
    logic [AWF:0]   cnt_reg;
    logic           push_ok;
    logic           pop_ok;

    // Honest full and empty straight from the count
    assign f.push_ready = cnt_reg != (AWF+1)'(DEPTH);
    assign f.pop_valid  = cnt_reg != '0;
    assign f.pop_data   = mem_reg[rd_reg];
    assign f.level      = cnt_reg;
    assign push_ok      = f.push_valid & f.push_ready;
    assign pop_ok       = f.pop_ready & f.pop_valid;

    // Storage needs no reset; only pointers and the count carry control meaning
    always_ff @(posedge clk) begin
        if (push_ok) begin
            mem_reg[wr_reg] <= f.push_data;
        end
    end

    // Pointers and fill count; depth is a power of two so pointers wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else if (f.flush) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_reg + AWF'(push_ok);
            rd_reg  <= rd_reg + AWF'(pop_ok);
            cnt_reg <= cnt_reg + (AWF+1)'(push_ok) - (AWF+1)'(pop_ok);
        end
    end

    a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
        (cnt_reg == (AWF+1)'(DEPTH)) && f.push_valid && !f.pop_ready
            |=> cnt_reg == (AWF+1)'(DEPTH))
        else $error("buffer count moved past its depth");
endmodule // spim_fifo

// >>> logic/spim_top.sv
// What this block does
// - Master only; the block makes the serial clock, no slave mode.
// - One master, one slave per transfer; each transfer moves one word.
// - All four clock polarity and phase modes selectable.
// - Half duplex: data line carries either outgoing or incoming word.
// - Word length programmable from one to sixteen bits.
// - Configurable least or most significant bit first.
// - One sixty-four by sixteen buffer serves the current direction.
// - Busy input from the slave holds off new words.
// - DMA requests to fill transmit and drain receive words.
// - Receive timeout interrupt under DMA when incoming data stops.
// - Timed interrupt prompting software to drain leftover words.
// - Clock and data pins released to general purpose use when off.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
module spim_top #(
    parameter int WORD_W = spim_pkg::WORD_W,
    parameter int DEPTH  = spim_pkg::DEPTH
) (
    // Clock and reset
    input  wire logic                     I_REF_CLK,
    input  wire logic                     I_ARST_N,
    // APB slave
    input  wire logic                     I_PSEL,
    input  wire logic                     I_PENABLE,
    input  wire logic                     I_PWRITE,
    input  wire logic [spim_pkg::AW-1:0]  I_PADDR,
    input  wire logic [31:0]              I_PWDATA,
    output logic      [31:0]              O_PRDATA,
    output logic                          O_PREADY,
    output logic                          O_PSLVERR,
    // Serial link
    output logic                          O_SCK,
    output logic                          O_SCK_OE,
    output logic                          O_SDIO_O,
    output logic                          O_SDIO_OE,
    input  wire logic                     I_SDIO_I,
    input  wire logic                     I_BUSY,
    // DMA and interrupt
    output logic                          O_DMA_TX_REQ,
    output logic                          O_DMA_RX_REQ,
    output logic                          O_IRQ,
    // Pin ownership: high while the controller owns the link pins
    output logic                          O_PIN_OWN
);
    import spim_pkg::*;

    spim_fifo_if #(.W(WORD_W), .DEPTH(DEPTH)) f ();

    spim_state_e       state_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [7:0]        div_reg;
    logic [15:0]       cnt_reg;
    logic [15:0]       tmo_reg;
    logic [15:0]       tcnt_reg;
    logic [EV_N-1:0]   ist_reg;
    logic [EV_N-1:0]   ien_reg;
    logic [EV_N-1:0]   ev;
    logic [31:0]       rdata;
    logic [31:0]       prdata_reg;
    logic              pready_reg;
    logic              rd_ok_reg;
    logic              busy_s1_reg;
    logic              busy_s2_reg;
    logic              din_s1_reg;
    logic              din_s2_reg;
    logic [7:0]        hcnt_reg;
    logic [5:0]        edge_reg;
    logic              sck_reg;
    logic [15:0]       tx_sh_reg;
    logic [15:0]       rx_sh_reg;
    logic [2:0]        samp_reg;
    logic [1:0]        tail_reg;
    logic              en;
    logic              cpha;
    logic              cpol;
    logic              lsb;
    logic              rx;
    logic              dma;
    logic [4:0]        wlen;
    logic [5:0]        edges;
    logic              acc;
    logic              done;
    logic              wr;
    logic              rd;
    logic              is_data;
    logic              start;
    logic              tick;
    logic              lead;
    logic              samp_edge;
    logic              shift_edge;
    logic              eng_push;
    logic              eng_pop;
    logic              tmo_cond;
    logic              tmo_fire;
    logic [15:0]       rx_word;

    // Register map decode for the error answer; the read mux decodes with its own case
    function automatic logic addr_hit(input logic [AW-1:0] a);
        return a == OFF_CTRL || a == OFF_DIV || a == OFF_DATA || a == OFF_STAT
            || a == OFF_CNT || a == OFF_ISTAT || a == OFF_ICLR || a == OFF_IEN
            || a == OFF_TMO;
    endfunction

    // Reverse the low n bits so the shifter always sends bit 0 first
    function automatic logic [15:0] rev_bits(input logic [15:0] w, input logic [4:0] n);
        logic [15:0] r;
        int          j;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            j = int'(n) - 1 - i;
            if (j >= 0) begin
                r[i] = w[j];
            end
        end
        return r;
    endfunction

    spim_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
        .clk   (I_REF_CLK),
        .rst_n (I_ARST_N),
        .f     (f.store)
    );

    // Control fields
    assign en    = ctrl_reg[CTRL_EN];
    assign cpha  = ctrl_reg[CTRL_CPHA];
    assign cpol  = ctrl_reg[CTRL_CPOL];
    assign lsb   = ctrl_reg[CTRL_LSB];
    assign rx    = ctrl_reg[CTRL_RX];
    assign dma   = ctrl_reg[CTRL_DMA];
    assign wlen  = {1'b0, ctrl_reg[CTRL_WL+:4]} + 5'h01;
    assign edges = {wlen, 1'b0};

    // APB handshake: one wait state so read data comes from a flip-flop
    assign acc       = I_PSEL & I_PENABLE;
    assign done      = acc & pready_reg;
    assign wr        = done & I_PWRITE;
    assign rd        = done & ~I_PWRITE;
    assign is_data   = I_PADDR == OFF_DATA;
    assign O_PREADY  = pready_reg;
    assign O_PRDATA  = prdata_reg;
    assign O_PSLVERR = done & ~addr_hit(I_PADDR);

    // Read mux; the clear register reads as zero
    always_comb begin
        rdata = '0;
        case (I_PADDR)
            OFF_CTRL:  rdata[CTRL_W-1:0] = ctrl_reg;
            OFF_DIV:   rdata[7:0] = div_reg;
            OFF_DATA:  rdata[WORD_W-1:0] = f.pop_data;
            OFF_STAT: begin
                rdata[STAT_LVL+:LVL_W] = LVL_W'(f.level);
                rdata[STAT_EMPTY]      = ~f.pop_valid;
                rdata[STAT_FULL]       = ~f.push_ready;
                rdata[STAT_ACT]        = state_reg != S_IDLE;
                rdata[STAT_BUSY]       = busy_s2_reg;
            end
            OFF_CNT:   rdata[15:0] = cnt_reg;
            OFF_ISTAT: rdata[EV_N-1:0] = ist_reg;
            OFF_IEN:   rdata[EV_N-1:0] = ien_reg;
            OFF_TMO:   rdata[15:0] = tmo_reg;
            default: ;
        endcase
    end

    // Bus answer registers; read data is captured in the wait cycle
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pready_reg <= 1'b0;
            prdata_reg <= '0;
            rd_ok_reg  <= 1'b0;
        end else begin
            pready_reg <= acc & ~pready_reg;
            if (acc && !pready_reg && !I_PWRITE) begin
                prdata_reg <= rdata;
                rd_ok_reg  <= f.pop_valid; // Pop only a word that was returned
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ctrl_reg <= CTRL_RST;
            div_reg  <= DIV_RST;
            tmo_reg  <= TMO_RST;
            ien_reg  <= '0;
        end else if (wr) begin
            case (I_PADDR)
                OFF_CTRL: begin
                    ctrl_reg             <= I_PWDATA[CTRL_W-1:0];
                    ctrl_reg[CTRL_FLUSH] <= 1'b0; // Flush is a strobe, not stored
                end
                OFF_DIV:  div_reg <= I_PWDATA[7:0];
                OFF_TMO:  tmo_reg <= I_PWDATA[15:0];
                OFF_IEN:  ien_reg <= I_PWDATA[EV_N-1:0];
                default: ;
            endcase
        end
    end

    // Words still to clock in; loaded by software, counted down per word
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cnt_reg <= '0;
        end else if (wr && I_PADDR == OFF_CNT) begin
            cnt_reg <= I_PWDATA[15:0];
        end else if (start && rx) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end
    end

    // Buffer serves one direction at a time: bus fills for send, engine for receive
    assign f.push_valid = rx ? eng_push : (wr & is_data);
    assign f.push_data  = rx ? rx_word : I_PWDATA[WORD_W-1:0];
    assign f.pop_ready  = rx ? (rd & is_data & rd_ok_reg) : eng_pop;
    assign f.flush      = wr & (I_PADDR == OFF_CTRL) & I_PWDATA[CTRL_FLUSH];

    // DMA requests follow buffer room when sending and buffered words when receiving
    assign O_DMA_TX_REQ = en & dma & ~rx & f.push_ready;
    assign O_DMA_RX_REQ = en & dma & rx & f.pop_valid;

    // Pin inputs pass two flip-flops before any logic looks at them
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
            din_s1_reg  <= 1'b0;
            din_s2_reg  <= 1'b0;
        end else begin
            busy_s1_reg <= I_BUSY;
            busy_s2_reg <= busy_s1_reg;
            din_s1_reg  <= I_SDIO_I;
            din_s2_reg  <= din_s1_reg;
        end
    end

    // A word starts only when enabled, the slave is not busy and work is queued
    assign start = en && state_reg == S_IDLE && !busy_s2_reg
                && (rx ? (cnt_reg != '0 && f.push_ready) : f.pop_valid);
    assign eng_pop  = start & ~rx;
    assign eng_push = rx && state_reg == S_TAIL && tail_reg == '0;

    // Edge bookkeeping: even edges lead, phase picks which ones sample
    assign tick       = state_reg == S_RUN && hcnt_reg == '0;
    assign lead       = ~edge_reg[0];
    assign samp_edge  = tick & (lead ^ cpha);
    assign shift_edge = tick & ~(lead ^ cpha) & (edge_reg != '0);

    // Word engine: one master, one slave, one word per pass
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state_reg <= S_IDLE;
            hcnt_reg  <= '0;
            edge_reg  <= '0;
            tail_reg  <= '0;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        state_reg <= S_RUN;
                        hcnt_reg  <= div_reg;
                        edge_reg  <= '0;
                    end
                end
                S_RUN: begin
                    if (tick) begin
                        hcnt_reg <= div_reg; // Half period is div+1 clocks
                        edge_reg <= edge_reg + 6'h01;
                        if (edge_reg == edges - 6'h01) begin
                            state_reg <= S_TAIL;
                            tail_reg  <= RX_LAT;
                        end
                    end else begin
                        hcnt_reg <= hcnt_reg - 8'h01;
                    end
                end
                S_TAIL: begin
                    // Waits out the input synchroniser before handing the word on
                    if (tail_reg == '0) begin
                        state_reg <= S_IDLE;
                    end else begin
                        tail_reg <= tail_reg - 2'h1;
                    end
                end
            endcase
        end
    end

    // Serial clock: made here, parked at the polarity level between words
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sck_reg <= 1'b0;
        end else if (state_reg == S_IDLE) begin
            sck_reg <= cpol;
        end else if (tick) begin
            sck_reg <= ~sck_reg;
        end
    end

    // Transmit shifter always sends bit 0; order is fixed at load time
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            tx_sh_reg <= '0;
        end else if (eng_pop) begin
            tx_sh_reg <= lsb ? 16'(f.pop_data) : rev_bits(16'(f.pop_data), wlen);
        end else if (shift_edge && !rx) begin
            tx_sh_reg <= {1'b0, tx_sh_reg[15:1]};
        end
    end

    // Sample strobe delayed to line up with the synchronised data input
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            samp_reg <= '0;
        end else begin
            samp_reg <= {samp_reg[1:0], samp_edge & rx};
        end
    end

    // Receive shifter; bit order chooses the end bits enter from
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rx_sh_reg <= '0;
        end else if (start) begin
            rx_sh_reg <= '0;
        end else if (samp_reg[2]) begin
            if (lsb) begin
                rx_sh_reg <= {din_s2_reg, rx_sh_reg[15:1]};
            end else begin
                rx_sh_reg <= {rx_sh_reg[14:0], din_s2_reg};
            end
        end
    end
    assign rx_word = lsb ? (rx_sh_reg >> (5'h10 - wlen)) : rx_sh_reg;

    // Line drive: data pin driven only while sending, never while receiving
    assign O_SCK     = sck_reg;
    assign O_SDIO_O  = tx_sh_reg[0];
    assign O_SDIO_OE = en & ~rx & (state_reg != S_IDLE);
    assign O_SCK_OE  = en;
    assign O_PIN_OWN = en;

    // Idle timer: words left in the buffer while nothing arrives
    assign tmo_cond = en && rx && f.pop_valid && state_reg == S_IDLE;
    assign tmo_fire = tmo_cond && tmo_reg != '0 && tcnt_reg == tmo_reg - 16'h0001;
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            tcnt_reg <= '0;
        end else if (!tmo_cond) begin
            tcnt_reg <= '0;
        end else if (tcnt_reg != tmo_reg) begin
            tcnt_reg <= tcnt_reg + 16'h0001;
        end
    end

    // Events: DMA receive timeout, drain prompt, end of a send sequence
    assign ev[EV_RXTMO]  = tmo_fire & dma;
    assign ev[EV_DRAIN]  = tmo_fire & ~dma;
    assign ev[EV_TXDONE] = ~rx && state_reg == S_TAIL && tail_reg == '0 && !f.pop_valid;

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ist_reg <= '0;
        end else if (wr && I_PADDR == OFF_ICLR) begin
            ist_reg <= (ist_reg & ~I_PWDATA[EV_N-1:0]) | ev;
        end else begin
            ist_reg <= ist_reg | ev;
        end
    end
    assign O_IRQ = |(ist_reg & ien_reg);

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);

    sequence s_word_done;
        state_reg == S_RUN ##1 state_reg == S_TAIL;
    endsequence

    a_edge_total: assert property (s_word_done |-> edge_reg == edges)
        else $error("word ended with wrong edge count");
    a_word_hand: assert property (s_word_done ##0 rx |-> ##3 eng_push)
        else $error("received word not handed on in time");
    a_busy_hold: assert property (state_reg == S_IDLE && busy_s2_reg |=> state_reg == S_IDLE)
        else $error("word started while slave busy");
    a_sck_idle: assert property ((state_reg == S_IDLE && $stable(cpol)) [*2] |-> sck_reg == cpol)
        else $error("idle clock level differs from polarity");
    a_sck_master: assert property ($changed(sck_reg) |-> $past(tick) || $past(state_reg) == S_IDLE)
        else $error("serial clock moved without own timing");
    a_oe_send: assert property (O_SDIO_OE |-> !rx && state_reg != S_IDLE)
        else $error("data pin driven while receiving");
    a_pins_free: assert property (!en |-> !O_SCK_OE && !O_SDIO_OE && !O_PIN_OWN)
        else $error("link pins held while disabled");
    a_dma_tx: assert property (O_DMA_TX_REQ |-> !f.level[$clog2(DEPTH)] && !rx && dma)
        else $error("transmit request without room");
    a_rx_tmo: assert property (tmo_fire && dma |=> ist_reg[EV_RXTMO])
        else $error("receive timeout not flagged");
    a_drain: assert property (tmo_fire && !dma |=> ist_reg[EV_DRAIN])
        else $error("drain prompt not flagged");
endmodule // spim_top

// >>> pkg/spim_fifo_if.sv
`timescale 1ns/10ps
interface spim_fifo_if #(parameter int W = 16, parameter int DEPTH = 64);
    logic                     push_valid;
    logic                     push_ready;
    logic [W-1:0]             push_data;
    logic                     pop_valid;
    logic                     pop_ready;
    logic [W-1:0]             pop_data;
    logic                     flush;
    logic [$clog2(DEPTH):0]   level;

    modport ctrl (output push_valid, push_data, pop_ready, flush,
                  input  push_ready, pop_valid, pop_data, level);
    modport store (input  push_valid, push_data, pop_ready, flush,
                   output push_ready, pop_valid, pop_data, level);
endinterface

// >>> pkg/spim_pkg.sv
package spim_pkg;
    // APB register offsets (byte addresses)
    localparam int          AW         = 8;
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_DIV    = 8'h04;
    localparam logic [7:0]  OFF_DATA   = 8'h08;
    localparam logic [7:0]  OFF_STAT   = 8'h0C;
    localparam logic [7:0]  OFF_CNT    = 8'h10;
    localparam logic [7:0]  OFF_ISTAT  = 8'h14;
    localparam logic [7:0]  OFF_ICLR   = 8'h18;
    localparam logic [7:0]  OFF_IEN    = 8'h1C;
    localparam logic [7:0]  OFF_TMO    = 8'h20;
    // Control field positions
    localparam int          CTRL_W     = 12;
    localparam int          CTRL_EN    = 0;
    localparam int          CTRL_CPHA  = 1;
    localparam int          CTRL_CPOL  = 2;
    localparam int          CTRL_LSB   = 3;
    localparam int          CTRL_RX    = 4;
    localparam int          CTRL_DMA   = 5;
    localparam int          CTRL_FLUSH = 6;
    localparam int          CTRL_WL    = 8;
    // Status field positions
    localparam int          STAT_LVL   = 0;
    localparam int          LVL_W      = 7;
    localparam int          STAT_EMPTY = 8;
    localparam int          STAT_FULL  = 9;
    localparam int          STAT_ACT   = 10;
    localparam int          STAT_BUSY  = 11;
    // Interrupt event bits
    localparam int          EV_N       = 3;
    localparam int          EV_RXTMO   = 0;
    localparam int          EV_DRAIN   = 1;
    localparam int          EV_TXDONE  = 2;
    // Reset values
    localparam logic [11:0] CTRL_RST   = 12'hF00;
    localparam logic [7:0]  DIV_RST    = 8'h01;
    // Timing: idle timeout default, in ns and in cycles of the 10 ns clock
    localparam int          CLK_NS     = 10;
    localparam int          TMO_NS     = 10000;
    localparam logic [15:0] TMO_RST    = 16'(TMO_NS / CLK_NS);
    // Cycles from last sampling edge to word hand-off (sync plus capture)
    localparam logic [1:0]  RX_LAT     = 2'h3;
    // Buffer shape
    localparam int          WORD_W     = 16;
    localparam int          DEPTH      = 64;

    typedef enum logic [1:0] {S_IDLE, S_RUN, S_TAIL} spim_state_e;
endpackage

// >>> verif/spim_slave_model.sv
`timescale 1ns/10ps
// Far-side slave: samples on the mode's sampling edge, shifts on the other
module spim_slave_model (
    // Link
    input  wire logic        i_sck,
    input  wire logic        i_sdio,
    input  wire logic        i_sdo_oe,
    input  wire logic        i_ss_n,
    output logic             o_sdi,
    // Setup and capture
    input  wire logic [1:0]  i_mode,
    input  wire logic [15:0] i_tx_word,
    output logic [15:0]      o_rx_word,
    output logic [4:0]       o_rx_cnt
);
    logic [15:0] sh_reg = 16'h0000;
    logic        first_reg = 1'b0;
    logic        armed_reg = 1'b1;
    // Deselected line shows the inverse of its last bit, so no stale value passes
    assign o_sdi = i_ss_n ? ~sh_reg[15] : sh_reg[15];
    // One process owns the model state: first event after select loads, later edges shift
    // Capture only while the master drives; with phase 1 the first shift is skipped
    always @(negedge i_ss_n or posedge i_ss_n or posedge i_sck or negedge i_sck) begin
        if (i_ss_n) begin
            armed_reg <= 1'b1;
        end else if (armed_reg) begin
            sh_reg    <= i_tx_word;
            first_reg <= 1'b1;
            o_rx_cnt  <= 5'h00;
            armed_reg <= 1'b0;
        end else if ((i_sck ^ i_mode[1] ^ i_mode[0]) && i_sdo_oe) begin
            o_rx_word <= {o_rx_word[14:0], i_sdio};
            o_rx_cnt  <= o_rx_cnt + 5'h01;
        end else if (!(i_sck ^ i_mode[1] ^ i_mode[0])) begin
            if (first_reg && i_mode[0]) begin
                first_reg <= 1'b0;
            end else begin
                sh_reg <= {sh_reg[14:0], ~sh_reg[15]};
            end
        end
    end
endmodule // spim_slave_model

// >>> verif/test_spim_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("Error at %0t: got %h, expected %h", $time, g, e); end end
module test_spim_top;
    import spim_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        ss_n = 1'b1, busy = 1'b0, err, pready, pslverr, sck, sck_oe;
    logic        sdo, sdo_oe, slave_d, txreq, rxreq, irq, own;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [1:0]  mode = 2'h0;
    logic [15:0] txw = 16'h0000, rxw;
    logic [4:0]  rxc;
    int          fail_count = 0, checks_done = 0, cyc = 0;
    wire         sdio = sdo_oe ? sdo : slave_d;
    always #5 clk = ~clk;
    spim_top spim_top_inst (.I_REF_CLK(clk), .I_ARST_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_SCK(sck),
        .O_SCK_OE(sck_oe), .O_SDIO_O(sdo), .O_SDIO_OE(sdo_oe), .I_SDIO_I(sdio),
        .I_BUSY(busy), .O_DMA_TX_REQ(txreq), .O_DMA_RX_REQ(rxreq), .O_IRQ(irq),
        .O_PIN_OWN(own));
    spim_slave_model spim_slave_model_inst (.i_sck(sck), .i_sdio(sdio), .i_sdo_oe(sdo_oe),
        .i_ss_n(ss_n), .o_sdi(slave_d), .i_mode(mode), .i_tx_word(txw), .o_rx_word(rxw),
        .o_rx_cnt(rxc));
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd   = prdata;
        err  = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    // Poll status; bounded so a stuck engine falls through to the checks
    task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
        int n = 0;
        do begin apb(1'b0, OFF_STAT, 32'h0); n++; end while ((rd & m) !== v && n < 300);
    endtask
    task automatic t_send(input logic [1:0] md, input logic lsb, input logic [15:0] w,
                          input int len);
        logic [15:0] e = 16'h0000;
        logic [15:0] m = 16'((32'h1 << len) - 1);
        for (int i = 0; i < len; i++) e[i] = lsb ? w[len-1-i] : w[i];
        mode <= md;
        apb(1'b1, OFF_CTRL, {20'h0, 4'(len - 1), 2'b01, 2'b00, lsb, md, 1'b1});
        ss_n <= 1'b0;
        apb(1'b1, OFF_DATA, {16'h0, w});
        wait_stat(32'h0000_0500, 32'h0000_0100);
        ss_n <= 1'b1;
        `CHK(rxw & m, e)
        `CHK(rxc, 5'(len))
        `CHK({sck, own, sck_oe}, {md[1], 2'b11})
        $display("Send test done, mode %0d", md);
    endtask
    task automatic t_recv();
        txw  <= 16'h3C5A;
        mode <= 2'h0;
        apb(1'b1, OFF_TMO, 32'h0000_0008);
        apb(1'b1, OFF_DIV, 32'h0000_0002);
        apb(1'b1, OFF_CTRL, 32'h0000_0F71);
        apb(1'b1, OFF_CNT, 32'h0000_0001);
        ss_n <= 1'b0; // Select after the clock has parked, or its fall shifts the slave
        wait_stat(32'h0000_047F, 32'h0000_0001);
        ss_n <= 1'b1;
        `CHK(rxreq, 1'b1)
        repeat (12) @(posedge clk);
        apb(1'b0, OFF_ISTAT, 32'h0);
        `CHK(rd[EV_RXTMO], 1'b1)
        apb(1'b1, OFF_CTRL, 32'h0000_0F11);
        apb(1'b1, OFF_TMO, 32'h0000_0010);
        repeat (12) @(posedge clk);
        apb(1'b0, OFF_ISTAT, 32'h0);
        `CHK(rd[EV_DRAIN], 1'b1)
        apb(1'b0, OFF_DATA, 32'h0);
        `CHK(rd, 32'h0000_3C5A)
        @(posedge clk);
        `CHK({rxc, rxreq, sdo_oe}, 7'h00)
        $display("Receive test done");
    endtask
    task automatic t_busy();
        busy <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'h0000_0761);
        ss_n <= 1'b0;
        apb(1'b1, OFF_DATA, 32'h0000_0081);
        repeat (30) @(posedge clk);
        apb(1'b0, OFF_STAT, 32'h0);
        `CHK({rd[STAT_BUSY], rd[STAT_EMPTY], rxc}, 7'h40)
        `CHK(txreq, 1'b1)
        busy <= 1'b0;
        wait_stat(32'h0000_0500, 32'h0000_0100);
        ss_n <= 1'b1;
        `CHK({rxc, rxw[7:0]}, {5'h08, 8'h81})
        $display("Busy test done");
    endtask
    // Verdict and end of run, shared with the hang guard
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hang guard well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        `CHK({sck, sck_oe, own, irq}, 4'h0)
        rst_n <= 1'b1;
        apb(1'b0, OFF_CTRL, 32'h0);
        `CHK(rd, {20'h0, CTRL_RST})
        apb(1'b0, 8'h40, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, OFF_DIV, 32'h0000_0001);
        t_send(2'h0, 1'b0, 16'h00A5, 8);
        t_send(2'h1, 1'b1, 16'h0001, 1);
        t_send(2'h2, 1'b0, 16'hBEEF, 16);
        t_send(2'h3, 1'b1, 16'h0135, 9);
        apb(1'b1, OFF_IEN, 32'h0000_0004);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        apb(1'b1, OFF_IEN, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        apb(1'b1, OFF_ICLR, 32'h0000_0004);
        apb(1'b0, OFF_ISTAT, 32'h0);
        `CHK(rd[EV_TXDONE], 1'b0)
        t_recv();
        t_busy();
        stop_test();
    end
endmodule // test_spim_top
